// ===== qps_defs.sv
// Constants, types and the select-line glitch filter for the quad pot serial control
// How it works
// [R1] Address then setting bits, LSB first
// [R2] Frame begins only after high start bit
// [R3] Sample input, update output on rising edge
// [R4] Host leaves two clocks between frames
// [R5] Select bits pick channel one to four
// [R6] Each channel holds an 8-bit setting
// [R7] Reset loads stored settings into channels
// [R8] Serial access and drive only while selected
// [R9] Deselect reloads channels, floats serial output
// [R10] Short select-low glitches are filtered out
// [R11] Unstored writes are temporary, memory untouched
// [R12] Only the addressed channel changes on a write
// [R13] Host keeps clock running through store
// [R14] Store request drives ready flag low
// [R15] Busy store ignores input, shifts nothing
// [R16] Supply low leaves ready high, no store
// [R17] After address, old setting shifts out
// [R18] Frame: start, two address, eight data
// [R19] Channel updates on cycle after last bit
// [R20] Host raises store before closing edge
// [R21] Every write also reads the old value
// [R22] Deselected device idles awaiting start bit
`timescale 1ns/1ns

// ---------------------------------------------------------------
// Package
// ---------------------------------------------------------------
package qps_pkg;
  localparam int CLK_PERIOD_NS = 50;            // System clock period
  localparam int FILT_MIN_NS   = 30;            // Shortest low that counts
  localparam int FILT_MAX_NS   = 90;            // Longest low still filtered
  // Least time rounds up, never below one cycle
  localparam int FILT_CYC_RAW  = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CYC      = (FILT_CYC_RAW < 1) ? 1 : FILT_CYC_RAW;
  localparam int BUSY_NS       = 5000000;       // Erase/write cycle, longest
  localparam int BUSY_CYC      = BUSY_NS / CLK_PERIOD_NS;
  localparam int NUM_CH        = 4;             // Channels
  localparam int DATA_BITS     = 8;             // Setting width
  localparam int ADDR_BITS     = 2;             // Channel address width
  localparam int GAP_EDGES     = 2;             // Edges after last bit
  localparam logic [7:0] NV_RESET = 8'h80;      // Stored value after power-up
  localparam logic [3:0] BIT_ADDR_LAST = 4'h1;  // Last address bit index
  localparam logic [3:0] BIT_DATA_LAST = 4'h7;  // Last data bit index
  localparam logic [3:0] BIT_GAP_LAST  = 4'h1;  // Last gap edge index
  localparam logic [3:0] FILT_LIM      = 4'(FILT_CYC);

  // Frame state, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_DATA = 5'h04,
    ST_GAP  = 5'h08,
    ST_BUSY = 5'h10
  } qps_state_t;

  // Host-side pins, all sampled on the system clock
  typedef struct packed {
    logic sel;          // Select line, high = selected
    logic sclk;         // Serial clock
    logic serial_in;    // Serial data in
    logic store_request;// Store request
    logic supply_low;   // Low supply detector
  } qps_pins_t;
endpackage

// ---------------------------------------------------------------
// Select filter
// ---------------------------------------------------------------
module qps_sel_filter (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic sel_raw,
  output logic      sel_ok
);
  logic [3:0] low_cnt_r;   // Consecutive low samples
  logic [3:0] low_cnt_nxt;
  logic       sel_r;       // Filtered select
  logic       sel_nxt;

  // A low must persist for the window before it acts as a reset
  always_comb begin
    if (sel_raw) begin
      low_cnt_nxt = 4'h0;
    end else if (low_cnt_r < qps_pkg::FILT_LIM) begin
      low_cnt_nxt = low_cnt_r + 4'h1;
    end else begin
      low_cnt_nxt = low_cnt_r;
    end
    sel_nxt = sel_raw | (low_cnt_nxt < qps_pkg::FILT_LIM); // R10
  end

  // Registers; reset treats the line as deselected
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_cnt_r <= qps_pkg::FILT_LIM;
      sel_r     <= 1'b0;
    end else begin
      low_cnt_r <= low_cnt_nxt;
      sel_r     <= sel_nxt;
    end
  end

  assign sel_ok = sel_r;
endmodule

// ===== qps_serial_ctrl.sv
// Serial frame engine, channel settings and stored-setting memory
`timescale 1ns/1ns

module qps_serial_ctrl #(
  parameter int BUSY_CYC = qps_pkg::BUSY_CYC  // Store time in clocks
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire qps_pkg::qps_pins_t pins,
  output logic                  serial_out,
  output logic                  serial_out_en,
  output logic                  store_ready_flag,
  output logic [7:0]            channel_output_one,
  output logic [7:0]            channel_output_two,
  output logic [7:0]            channel_output_three,
  output logic [7:0]            channel_output_four
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic               sel_f;        // Filtered select
  logic               sclk_d_r;     // Previous serial clock sample
  logic               store_d_r;    // Previous store request sample
  logic               rise;         // Serial clock rising edge
  logic               store_rise;   // Store request rising edge
  qps_pkg::qps_state_t state_r, state_nxt;
  logic [3:0]         bit_r, bit_nxt;       // Bit index in phase
  logic [1:0]         addr_r, addr_nxt;     // Channel address
  logic [7:0]         din_r, din_nxt;       // Incoming setting
  logic [7:0]         dout_r, dout_nxt;     // Old setting shifting out
  logic               so_r, so_nxt;         // Serial output bit
  logic               pend_r, pend_nxt;     // Store armed for frame
  logic [16:0]        busy_r, busy_nxt;     // Store timer
  logic               wr_en;                // Apply din to channel
  logic               nv_wr;                // Commit din to memory
  logic [3:0][7:0]    ch_r, ch_nxt;         // Live settings
  logic [3:0][7:0]    nv_r, nv_nxt;         // Stored settings
  logic [1:0]         rd_sel;               // Channel to read back

  qps_sel_filter u_filter (
    .clock   (clock),
    .sys_rst (sys_rst),
    .sel_raw (pins.sel),
    .sel_ok  (sel_f)
  );

  // Edges of the serial clock are seen in the system clock domain
  assign rise       = pins.sclk & ~sclk_d_r;           // R3
  assign store_rise = pins.store_request & ~store_d_r;
  assign rd_sel     = {pins.serial_in, addr_r[0]};

  // ---------------------------------------------------------------
  // Frame state machine
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    bit_nxt   = bit_r;
    addr_nxt  = addr_r;
    din_nxt   = din_r;
    dout_nxt  = dout_r;
    so_nxt    = so_r;
    pend_nxt  = pend_r;
    busy_nxt  = busy_r;
    wr_en     = 1'b0;
    nv_wr     = 1'b0;
    case (state_r)
      qps_pkg::ST_IDLE: begin
        so_nxt   = 1'b0;
        pend_nxt = 1'b0;
        // Wait for the high start bit
        if (sel_f && rise && pins.serial_in) begin // R2
          state_nxt = qps_pkg::ST_ADDR;
          bit_nxt   = 4'h0;
        end
      end
      qps_pkg::ST_ADDR: begin
        if (rise) begin
          addr_nxt[bit_r[0]] = pins.serial_in; // R1
          bit_nxt            = bit_r + 4'h1;
          if (bit_r == qps_pkg::BIT_ADDR_LAST) begin
            // Old setting leaves LSB first, starting on this edge
            so_nxt    = ch_r[rd_sel][0]; // R17
            dout_nxt  = {1'b0, ch_r[rd_sel][7:1]};
            state_nxt = qps_pkg::ST_DATA;
            bit_nxt   = 4'h0;
          end
        end
      end
      qps_pkg::ST_DATA: begin
        if (rise) begin
          din_nxt  = {pins.serial_in, din_r[7:1]}; // R1
          so_nxt   = dout_r[0]; // R21
          dout_nxt = {1'b0, dout_r[7:1]};
          bit_nxt  = bit_r + 4'h1;
          if (bit_r == qps_pkg::BIT_DATA_LAST) begin // R18
            state_nxt = qps_pkg::ST_GAP;
            bit_nxt   = 4'h0;
          end
        end
      end
      qps_pkg::ST_GAP: begin
        if (rise) begin
          so_nxt  = 1'b0;
          bit_nxt = bit_r + 4'h1;
          if (bit_r == 4'h0) begin
            wr_en = 1'b1; // R19
            if (pend_r) begin
              state_nxt = qps_pkg::ST_BUSY;
              busy_nxt  = 17'h0;
            end
          end else if (bit_r == qps_pkg::BIT_GAP_LAST) begin
            state_nxt = qps_pkg::ST_IDLE;
          end
        end
      end
      qps_pkg::ST_BUSY: begin
        // Input ignored and nothing shifted while the cells program
        so_nxt   = 1'b0; // R15
        busy_nxt = busy_r + 17'h1;
        if (busy_r == 17'(BUSY_CYC - 1)) begin
          nv_wr     = 1'b1;
          pend_nxt  = 1'b0;
          state_nxt = qps_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = qps_pkg::ST_IDLE;
      end
    endcase
    // Store arms only with a healthy supply; a low supply leaves ready high.
    // A request may still arrive after the last bit, ahead of the apply edge;
    // one landing on that very edge is too late and is refused.
    if ((state_r == qps_pkg::ST_ADDR || state_r == qps_pkg::ST_DATA
         || (state_r == qps_pkg::ST_GAP && bit_r == 4'h0 && !rise))
        && store_rise && !pins.supply_low) begin // R14 R16
      pend_nxt = 1'b1;
    end
    // Deselect aborts a frame, but a running store completes
    if (!sel_f && state_r != qps_pkg::ST_BUSY) begin // R22 R8
      state_nxt = qps_pkg::ST_IDLE;
      bit_nxt   = 4'h0;
      so_nxt    = 1'b0;
      pend_nxt  = 1'b0;
      wr_en     = 1'b0;
    end
  end

  // Registers of the frame state machine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sclk_d_r  <= 1'b0;
      store_d_r <= 1'b0;
      state_r   <= qps_pkg::ST_IDLE;
      bit_r     <= 4'h0;
      addr_r    <= 2'h0;
      din_r     <= 8'h00;
      dout_r    <= 8'h00;
      so_r      <= 1'b0;
      pend_r    <= 1'b0;
      busy_r    <= 17'h0;
    end else begin
      sclk_d_r  <= pins.sclk;
      store_d_r <= pins.store_request;
      state_r   <= state_nxt;
      bit_r     <= bit_nxt;
      addr_r    <= addr_nxt;
      din_r     <= din_nxt;
      dout_r    <= dout_nxt;
      so_r      <= so_nxt;
      pend_r    <= pend_nxt;
      busy_r    <= busy_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Channel settings and stored memory
  // ---------------------------------------------------------------
  // Per channel: deselect reloads, a write touches only its own channel
  for (genvar g = 0; g < qps_pkg::NUM_CH; g++) begin : g_ch
    always_comb begin
      if (!sel_f) begin
        ch_nxt[g] = nv_r[g]; // R9 R11
      end else if (wr_en && addr_r == 2'(g)) begin
        ch_nxt[g] = din_r; // R5 R12
      end else begin
        ch_nxt[g] = ch_r[g];
      end
      nv_nxt[g] = (nv_wr && addr_r == 2'(g)) ? din_r : nv_r[g]; // R11
    end
  end

  // Power-up loads the stored value with no serial clock needed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ch_r <= {qps_pkg::NUM_CH{qps_pkg::NV_RESET}}; // R7 R6
      nv_r <= {qps_pkg::NUM_CH{qps_pkg::NV_RESET}};
    end else begin
      ch_r <= ch_nxt;
      nv_r <= nv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign serial_out           = so_r;
  assign serial_out_en        = sel_f && state_r != qps_pkg::ST_BUSY; // R8 R9
  assign store_ready_flag     = !(pend_r || state_r == qps_pkg::ST_BUSY); // R14
  assign channel_output_one   = ch_r[0];
  assign channel_output_two   = ch_r[1];
  assign channel_output_three = ch_r[2];
  assign channel_output_four  = ch_r[3];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_store_go;
    state_r == qps_pkg::ST_GAP && rise && bit_r == 4'h0 && pend_r && sel_f;
  endsequence
  sequence s_addr_done;
    state_r == qps_pkg::ST_ADDR && rise && bit_r == qps_pkg::BIT_ADDR_LAST && sel_f;
  endsequence

  start_gate_a: assert property ( // R2
    state_r == qps_pkg::ST_IDLE && rise && !pins.serial_in |=> state_r == qps_pkg::ST_IDLE)
    else $error("frame started without start bit");
  addr_order_a: assert property ( // R1
    state_r == qps_pkg::ST_ADDR && rise && bit_r == 4'h0 && sel_f
    |=> addr_r[0] == $past(pins.serial_in))
    else $error("address low bit not taken first");
  read_first_a: assert property ( // R17
    s_addr_done |=> serial_out == $past(ch_r[rd_sel][0]) && state_r == qps_pkg::ST_DATA)
    else $error("old setting bit zero not shifted out");
  write_apply_a: assert property ( // R19
    state_r == qps_pkg::ST_GAP && rise && bit_r == 4'h0 && sel_f
    |=> ch_r[$past(addr_r)] == $past(din_r))
    else $error("channel not updated after last bit");
  sel_reload_a: assert property ( // R9
    !sel_f |-> !serial_out_en ##1 ch_r == $past(nv_r))
    else $error("deselect did not reload or float output");
  nv_hold_a: assert property ( // R11
    state_r != qps_pkg::ST_BUSY |=> nv_r == $past(nv_r))
    else $error("stored settings changed without store");
  busy_hold_a: assert property ( // R14
    s_store_go |=> (state_r == qps_pkg::ST_BUSY && !store_ready_flag) [*8])
    else $error("ready not low through store");
  busy_quiet_a: assert property ( // R15
    state_r == qps_pkg::ST_BUSY |-> !serial_out_en ##1 $stable(din_r))
    else $error("serial activity during store");
  low_supply_a: assert property ( // R16
    store_rise && pins.supply_low && store_ready_flag |=> store_ready_flag)
    else $error("store armed under low supply");
endmodule

// ===== qps_host_model.sv
// Host model that drives the three-wire control bus of the quad pot block
`timescale 1ns/1ns

module qps_host #(
  parameter int HALF = 3                  // System clocks per serial clock half period
) (
  input  wire logic         clock,
  input  wire logic         serial_out,
  input  wire logic         serial_out_en,
  input  wire logic         store_ready_flag,
  output qps_pkg::qps_pins_t pins,
  output logic              rd_valid,
  output logic [7:0]        rd_byte,
  output logic              rdy_seen
);
  logic in_frame;                         // High while a frame owns the data line

  initial begin
    pins = '0;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
    rdy_seen = 1'b1;
    in_frame = 1'b0;
  end

  // ---------------------------------------------------------------
  // Idle line
  // ---------------------------------------------------------------
  // Data toggles outside frames so a stale level can never pass for data
  always @(posedge clock) begin
    if (!in_frame) begin
      pins.serial_in <= ~pins.serial_in;
    end
  end

  // Select and supply level, then let the filter and enable settle
  task automatic drive(input logic s, input logic lo);
    @(posedge clock);
    pins.sel        <= s;
    pins.supply_low <= lo;
    repeat (4) @(posedge clock);
  endtask

  // One serial bit: data set up a half period ahead of the rise
  task automatic sbit(input logic b, output logic so);
    @(posedge clock);
    pins.sclk      <= 1'b0;
    pins.serial_in <= b;
    repeat (HALF) @(posedge clock);
    pins.sclk <= 1'b1;
    repeat (HALF) @(posedge clock);
    // A released line shows the inverse of the held bit, so floating is seen
    so = serial_out_en ? serial_out : ~serial_out;
  endtask

  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  task automatic frame(input logic [1:0] a, input logic [7:0] d, input logic st, input int pre);
    logic [10:0] bits;
    logic [7:0]  rd;
    logic        so;
    bits = {d, a, 1'b1};                  // Start, address, setting, LSB first
    in_frame = 1'b1;
    for (int i = 0; i < pre; i++) sbit(1'b0, so);  // Zeros ahead of the start bit
    for (int i = 0; i < 11; i++) begin
      sbit(bits[i], so);
      if (i >= 2 && i <= 9) rd[i-2] = so;
      // Even channels raise store after the start bit, odd ones after the last bit
      if (i == (a[0] ? 10 : 0) && st) pins.store_request <= 1'b1;
    end
    sbit(1'b0, so);                       // First gap rise applies the write
    rdy_seen = store_ready_flag;
    if (!rdy_seen) begin
      // Ones while storing, well inside the busy time, must be ignored
      for (int i = 0; i < 2; i++) sbit(1'b1, so);
    end
    sbit(1'b0, so);                       // Second gap rise
    for (int n = 0; n < 400 && !store_ready_flag; n++) sbit(1'b0, so);  // Clock kept running
    @(posedge clock);
    pins.sclk          <= 1'b0;           // Clock stands still low between frames
    pins.store_request <= 1'b0;
    rd_byte            <= rd;
    rd_valid           <= 1'b1;
    @(posedge clock);
    rd_valid <= 1'b0;
    in_frame = 1'b0;
  endtask
endmodule

// ===== qps_serial_ctrl_tb.sv
// Self-checking testbench for the quad pot serial control block
`timescale 1ns/1ns

module qps_serial_ctrl_tb;
  localparam int BUSY = 24;               // Shortened store time in clocks
  logic               clock;
  logic               sys_rst;
  qps_pkg::qps_pins_t pins;
  logic               serial_out;
  logic               serial_out_en;
  logic               store_ready_flag;
  logic [7:0]         ch1, ch2, ch3, ch4;
  logic               rd_valid;
  logic               rdy_seen;
  logic [7:0]         rd_byte;
  logic [7:0]         live [4];           // Expected live settings
  logic [7:0]         nv [4];             // Expected stored settings
  logic [7:0]         exp_q [$];          // Expected read-back bytes, oldest first
  logic               sel_on;             // Select state as the bench set it
  logic               lo;                 // Supply-low level as the bench set it
  logic [31:0]        rng;                // Xorshift state
  int                 err_count;
  int                 n_compared;
  int                 cyc;

  qps_serial_ctrl #(.BUSY_CYC(BUSY)) uut (
    .clock(clock), .sys_rst(sys_rst), .pins(pins), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .store_ready_flag(store_ready_flag),
    .channel_output_one(ch1), .channel_output_two(ch2),
    .channel_output_three(ch3), .channel_output_four(ch4)
  );

  qps_host host (
    .clock(clock), .serial_out(serial_out), .serial_out_en(serial_out_en),
    .store_ready_flag(store_ready_flag), .pins(pins), .rd_valid(rd_valid),
    .rd_byte(rd_byte), .rdy_seen(rdy_seen)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // One write frame; a deselected device leaves the line released, read as ones
  task automatic wr(input logic [1:0] a, input logic [7:0] d, input logic st);
    exp_q.push_back(sel_on ? live[a] : 8'hff);
    host.frame(a, d, st, int'(xs() % 3));
    if (sel_on) live[a] = d;
    if (sel_on && st && !lo) nv[a] = d;
    if (sel_on && st) chk({31'h0, rdy_seen}, {31'h0, lo});
    chk({31'h0, store_ready_flag}, 32'h1);
    chk({ch4, ch3, ch2, ch1}, {live[3], live[2], live[1], live[0]});
  endtask

  // Read-back watcher: each finished frame takes the oldest note
  always @(posedge clock) begin
    if (rd_valid === 1'b1) begin
      chk({24'h0, rd_byte}, {24'h0, exp_q.pop_front()});
    end
  end

  // Timeout
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    err_count = 0;
    n_compared = 0;
    cyc = 0;
    rng = 32'd72;
    sel_on = 1'b0;
    lo = 1'b0;
    for (int i = 0; i < 4; i++) begin
      live[i] = qps_pkg::NV_RESET;
      nv[i] = qps_pkg::NV_RESET;
    end
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    chk({ch4, ch3, ch2, ch1}, {4{qps_pkg::NV_RESET}});
    host.drive(1'b1, 1'b0);
    sel_on = 1'b1;
    // Every channel twice, back to back with zero to two idle bits before each start bit
    for (int i = 0; i < 8; i++) wr(2'(i), 8'(xs()), 1'b0);
    wr(2'h2, 8'(xs()), 1'b1);             // Stored write, busy ignores input
    wr(2'h3, 8'(xs()), 1'b1);             // Store raised late, in the gap
    lo = 1'b1;
    host.drive(1'b1, 1'b1);
    wr(2'h1, 8'(xs()), 1'b1);             // Store refused on low supply
    lo = 1'b0;
    host.drive(1'b0, 1'b0);
    sel_on = 1'b0;
    for (int i = 0; i < 4; i++) live[i] = nv[i];
    chk({ch4, ch3, ch2, ch1}, {nv[3], nv[2], nv[1], nv[0]});
    chk({31'h0, serial_out_en}, 32'h0);
    wr(2'h3, 8'hff, 1'b0);                // Ignored while deselected
    host.drive(1'b1, 1'b0);
    sel_on = 1'b1;
    wr(2'h0, 8'h00, 1'b0);                // Boundary settings
    wr(2'h3, 8'hff, 1'b0);
    wr(2'h2, 8'h5a, 1'b0);
    give_verdict();
  end
endmodule
